// ===== lesid_regs.sv
/*
  link enhancement control (low half) and subsystem id alias registers,
  reached as an apb3 slave with one wait state.
  assumes the host controller supplies its enhancement gate and the
  current transmit stream format on this clock; global_reset_n is a pin.
*/
`timescale 1ns/10ps
module lesid_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic global_reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic phy_enhancement_gate,
  input wire logic [5:0] stream_format_code,
  input wire lesid_pkg::lesid_eeprom_t eeprom_load,
  output logic timestamp_enhance_active,
  output logic priority_arb_enable,
  output logic phy_accel_notify,
  output logic phy_program_permit,
  output logic [15:0] subsystem_device_alias,
  output logic [15:0] subsystem_vendor_alias
);
  // ----------------------------------------------------------------
  // global reset synchroniser
  // ----------------------------------------------------------------
  // no reset on these flops: sys_rst must not fake a global reset
  logic global_reset_n_meta_reg;
  logic global_reset_n_sync_reg;
  logic global_reset_n_active;

  always_ff @(posedge clk)
  begin
    global_reset_n_meta_reg <= global_reset_n;
    global_reset_n_sync_reg <= global_reset_n_meta_reg;
  end

  assign global_reset_n_active = ~global_reset_n_sync_reg;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup_phase;
  logic access_done;
  logic wr_enh;
  logic wr_alias;
  logic hit_enh;
  logic hit_alias;
  logic hit_subsys;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign hit_enh = (paddr == lesid_pkg::LESID_ENH_OFFSET);
  assign hit_alias = (paddr == lesid_pkg::LESID_ALIAS_OFFSET);
  assign hit_subsys = (paddr == lesid_pkg::LESID_SUBSYS_OFFSET);
  assign wr_enh = access_done & pwrite & hit_enh;
  assign wr_alias = access_done & pwrite & hit_alias;

  // ----------------------------------------------------------------
  // enhancement control storage
  // ----------------------------------------------------------------
  // only the four functional bits have storage, so every reserved
  // slot, bit 6 included, reads zero and shrugs off writes
  lesid_pkg::lesid_enh_t enh_reg;
  lesid_pkg::lesid_enh_t enh_next;

  always_comb
  begin
    enh_next = enh_reg;
    if (wr_enh)
    begin
      enh_next.mpeg_timestamp_enable = pwdata[lesid_pkg::LESID_MPEG_BIT];
      enh_next.dv_timestamp_enable = pwdata[lesid_pkg::LESID_DV_BIT];
      enh_next.priority_request_enable = pwdata[lesid_pkg::LESID_PRIO_BIT];
      enh_next.accel_enable = pwdata[lesid_pkg::LESID_ACCEL_BIT];
    end
    else if (eeprom_load.valid)
    begin
      enh_next.mpeg_timestamp_enable = eeprom_load.data[lesid_pkg::LESID_MPEG_BIT];
      enh_next.dv_timestamp_enable = eeprom_load.data[lesid_pkg::LESID_DV_BIT];
      enh_next.priority_request_enable = eeprom_load.data[lesid_pkg::LESID_PRIO_BIT];
      enh_next.accel_enable = eeprom_load.data[lesid_pkg::LESID_ACCEL_BIT];
    end
  end

  // sys_rst deliberately absent: these bits survive it
  always_ff @(posedge clk)
  begin
    if (global_reset_n_active)
      enh_reg <= lesid_pkg::LESID_ENH_RESET;
    else
      enh_reg <= enh_next;
  end

  // eeprom bit 6 belongs to the host controller, forward it there
  logic prog_permit_reg;

  always_ff @(posedge clk)
  begin
    if (global_reset_n_active)
      prog_permit_reg <= 1'b0;
    else if (eeprom_load.valid)
      prog_permit_reg <= eeprom_load.data[lesid_pkg::LESID_PROG_BIT];
  end

  // ----------------------------------------------------------------
  // subsystem alias and id registers
  // ----------------------------------------------------------------
  logic [31:0] alias_reg;
  logic [31:0] subsys_id_reg;

  always_ff @(posedge clk)
  begin
    if (global_reset_n_active)
    begin
      alias_reg <= lesid_pkg::LESID_ALIAS_RESET;
      subsys_id_reg <= lesid_pkg::LESID_ALIAS_RESET;
    end
    else if (wr_alias)
    begin
      alias_reg <= pwdata;
      subsys_id_reg <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] enh_word;
  logic [31:0] rdata_next;

  always_comb
  begin
    enh_word = lesid_pkg::LESID_ZERO_WORD;
    enh_word[lesid_pkg::LESID_MPEG_BIT] = enh_reg.mpeg_timestamp_enable;
    enh_word[lesid_pkg::LESID_DV_BIT] = enh_reg.dv_timestamp_enable;
    enh_word[lesid_pkg::LESID_PRIO_BIT] = enh_reg.priority_request_enable;
    enh_word[lesid_pkg::LESID_ACCEL_BIT] = enh_reg.accel_enable;
    if (hit_enh)
      rdata_next = enh_word;
    else if (hit_alias)
      rdata_next = alias_reg;
    else if (hit_subsys)
      rdata_next = subsys_id_reg;
    else
      rdata_next = lesid_pkg::LESID_ZERO_WORD;
  end

  // ----------------------------------------------------------------
  // apb response: one wait state, data latched at setup
  // ----------------------------------------------------------------
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pready_reg <= 1'b0;
    else
      pready_reg <= setup_phase;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pslverr_reg <= 1'b0;
    else if (setup_phase)
      pslverr_reg <= ~(hit_enh | hit_alias | (hit_subsys & ~pwrite));
    else
      pslverr_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      prdata_reg <= lesid_pkg::LESID_ZERO_WORD;
    else if (setup_phase & ~pwrite)
      prdata_reg <= rdata_next;
  end

  // ----------------------------------------------------------------
  // enhancement outputs, gated by the host controller
  // ----------------------------------------------------------------
  logic ts_active_reg;
  logic prio_reg;
  logic accel_reg;
  logic mpeg_hit;
  logic dv_hit;

  assign mpeg_hit = enh_reg.mpeg_timestamp_enable &
                    (stream_format_code == lesid_pkg::LESID_FMT_MPEG);
  assign dv_hit = enh_reg.dv_timestamp_enable &
                  (stream_format_code == lesid_pkg::LESID_FMT_DV);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ts_active_reg <= 1'b0;
      prio_reg <= 1'b0;
      accel_reg <= 1'b0;
    end
    else
    begin
      ts_active_reg <= phy_enhancement_gate & (mpeg_hit | dv_hit);
      prio_reg <= phy_enhancement_gate & enh_reg.priority_request_enable;
      accel_reg <= phy_enhancement_gate & enh_reg.accel_enable;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign timestamp_enhance_active = ts_active_reg;
  assign priority_arb_enable = prio_reg;
  assign phy_accel_notify = accel_reg;
  assign phy_program_permit = prog_permit_reg;
  assign subsystem_device_alias = subsys_id_reg[31:lesid_pkg::LESID_DEV_LSB];
  assign subsystem_vendor_alias = subsys_id_reg[15:lesid_pkg::LESID_VEN_LSB];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_done;
    psel && penable && pready;
  endsequence

  a_access_one_wait: assert property (@(posedge clk) disable iff (sys_rst)
    s_setup |=> pready)
    else $error("apb access did not complete after one wait state");

  a_rsvd_read_zero: assert property (@(posedge clk)
    disable iff (sys_rst || global_reset_n_active)
    (s_setup and (hit_enh && !pwrite)) |=>
      (prdata & 32'hffff_fa7d) == 32'h0000_0000)
    else $error("reserved enhancement bits read nonzero");

  a_bit6_no_store: assert property (@(posedge clk)
    disable iff (sys_rst || global_reset_n_active)
    (s_setup and (hit_enh && !pwrite)) |=> !prdata[lesid_pkg::LESID_PROG_BIT])
    else $error("enhancement bit 6 read as one");

  a_enh_write_load: assert property (@(posedge clk)
    disable iff (sys_rst || global_reset_n_active)
    (s_done and (pwrite && hit_enh)) |=>
      enh_reg.mpeg_timestamp_enable == $past(pwdata[lesid_pkg::LESID_MPEG_BIT]) &&
      enh_reg.accel_enable == $past(pwdata[lesid_pkg::LESID_ACCEL_BIT]))
    else $error("enhancement write did not land");

  a_mpeg_stream: assert property (@(posedge clk)
    disable iff (sys_rst || global_reset_n_active)
    (phy_enhancement_gate && enh_reg.mpeg_timestamp_enable &&
     stream_format_code == lesid_pkg::LESID_FMT_MPEG) |=> timestamp_enhance_active)
    else $error("mpeg timestamp enhancement not applied");

  a_dv_stream: assert property (@(posedge clk)
    disable iff (sys_rst || global_reset_n_active)
    (phy_enhancement_gate && enh_reg.dv_timestamp_enable &&
     stream_format_code == lesid_pkg::LESID_FMT_DV) |=> timestamp_enhance_active)
    else $error("dv timestamp enhancement not applied");

  a_gate_blocks: assert property (@(posedge clk)
    disable iff (sys_rst)
    !phy_enhancement_gate |=>
      !timestamp_enhance_active && !priority_arb_enable && !phy_accel_notify)
    else $error("enhancement active without gate");

  a_prio_follow: assert property (@(posedge clk)
    disable iff (sys_rst || global_reset_n_active)
    (phy_enhancement_gate && enh_reg.priority_request_enable) |=> priority_arb_enable)
    else $error("priority arbitration not enabled");

  a_accel_follow: assert property (@(posedge clk)
    disable iff (sys_rst || global_reset_n_active)
    (phy_enhancement_gate && enh_reg.accel_enable) |=> phy_accel_notify)
    else $error("phy not told of acceleration support");

  a_alias_mirror: assert property (@(posedge clk)
    disable iff (sys_rst || global_reset_n_active)
    (s_done and (pwrite && hit_alias)) |=>
      alias_reg == $past(pwdata) && subsys_id_reg == $past(pwdata))
    else $error("alias write not mirrored to id registers");

  a_alias_readback: assert property (@(posedge clk)
    disable iff (sys_rst || global_reset_n_active)
    (s_setup and (hit_alias && !pwrite)) |=> prdata == $past(alias_reg))
    else $error("alias read returned wrong value");

  a_global_reset_n_clears: assert property (@(posedge clk)
    global_reset_n_active |=>
      alias_reg == lesid_pkg::LESID_ALIAS_RESET && enh_reg == lesid_pkg::LESID_ENH_RESET)
    else $error("global reset did not clear sticky bits");

  // global_reset_n_sync_reg keeps the power-up unknowns of the sticky bits out of this check
  a_sysrst_keeps: assert property (@(posedge clk)
    disable iff (global_reset_n_active)
    (sys_rst && global_reset_n_sync_reg && !wr_alias && !wr_enh && !eeprom_load.valid) |=>
      $stable(alias_reg) && $stable(enh_reg))
    else $error("sys_rst disturbed sticky bits");

  // a software write on the same edge wins, so only a lone load is checked here
  sequence s_eeprom_only;
    eeprom_load.valid && !wr_enh;
  endsequence

  a_eeprom_load: assert property (@(posedge clk)
    disable iff (global_reset_n_active)
    s_eeprom_only |=>
      enh_reg.dv_timestamp_enable == $past(eeprom_load.data[lesid_pkg::LESID_DV_BIT]) &&
      enh_reg.priority_request_enable == $past(eeprom_load.data[lesid_pkg::LESID_PRIO_BIT]))
    else $error("eeprom load did not reach enhancement bits");

  a_permit_load: assert property (@(posedge clk)
    disable iff (global_reset_n_active)
    eeprom_load.valid |=>
      phy_program_permit == $past(eeprom_load.data[lesid_pkg::LESID_PROG_BIT]))
    else $error("eeprom bit 6 not forwarded to the host controller");

  a_subsys_read: assert property (@(posedge clk)
    disable iff (sys_rst || global_reset_n_active)
    (s_setup and (hit_subsys && !pwrite)) |=> prdata == $past(subsys_id_reg))
    else $error("id register read returned wrong value");
endmodule : lesid_regs

// ===== lesid_pkg.sv
/*
  constants and carrier types for the link enhancement and subsystem
  identification register bank.
  assumes a 32-bit apb3 slave port and a 6-bit stream format code.
*/
package lesid_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] LESID_ENH_OFFSET = 8'hf4;
  localparam logic [7:0] LESID_ALIAS_OFFSET = 8'hf8;
  localparam logic [7:0] LESID_SUBSYS_OFFSET = 8'h2c;

  // ----------------------------------------------------------------
  // enhancement control field positions
  // ----------------------------------------------------------------
  localparam int LESID_MPEG_BIT = 10;
  localparam int LESID_DV_BIT = 8;
  localparam int LESID_PRIO_BIT = 7;
  localparam int LESID_PROG_BIT = 6;
  localparam int LESID_ACCEL_BIT = 1;

  // ----------------------------------------------------------------
  // alias field positions and reset values
  // ----------------------------------------------------------------
  localparam int LESID_DEV_LSB = 16;
  localparam int LESID_VEN_LSB = 0;
  localparam logic [31:0] LESID_ALIAS_RESET = 32'h0000_0000;
  localparam logic [31:0] LESID_ZERO_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // stream format codes
  // ----------------------------------------------------------------
  localparam logic [5:0] LESID_FMT_MPEG = 6'h20;
  localparam logic [5:0] LESID_FMT_DV = 6'h00;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic mpeg_timestamp_enable;
    logic dv_timestamp_enable;
    logic priority_request_enable;
    logic accel_enable;
  } lesid_enh_t;

  localparam lesid_enh_t LESID_ENH_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } lesid_eeprom_t;
endpackage : lesid_pkg

// ===== tb_lesid_regs.sv
/*
  self-checking bench for lesid_regs: apb register access, enhancement
  outputs, eeprom load, and the two resets.
  assumes a 250 MHz clock and the one-wait-state apb slave of the design.
*/
`timescale 1ns/10ps
module tb_lesid_regs;
  // ----------------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------------
  localparam logic [31:0] ENH_RW = 32'h0000_0582;
  logic clk, sys_rst, global_reset_n, psel, penable, pwrite;
  logic phy_enhancement_gate, pready, pslverr, er;
  logic timestamp_enhance_active, priority_arb_enable, phy_accel_notify, phy_program_permit;
  logic [7:0] paddr;
  logic [5:0] stream_format_code;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] subsystem_device_alias, subsystem_vendor_alias;
  lesid_pkg::lesid_eeprom_t eeprom_load;
  int errors;
  int checked;

  lesid_regs u_lesid_regs (
    .clk(clk), .sys_rst(sys_rst), .global_reset_n(global_reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phy_enhancement_gate(phy_enhancement_gate),
    .stream_format_code(stream_format_code), .eeprom_load(eeprom_load),
    .timestamp_enhance_active(timestamp_enhance_active),
    .priority_arb_enable(priority_arb_enable), .phy_accel_notify(phy_accel_notify),
    .phy_program_permit(phy_program_permit),
    .subsystem_device_alias(subsystem_device_alias),
    .subsystem_vendor_alias(subsystem_vendor_alias)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task test_done;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // outputs are read just after the edge, so they still hold what the previous edge loaded
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      errors++;
      test_done;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic e, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
    chk("read_err", {31'h0, e}, {31'h0, er});
  endtask : rd_chk

  task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk("write_err", {31'h0, e}, {31'h0, er});
  endtask : wr

  // outputs lag the stored bits and the gate by one register stage
  task out_chk(input logic [31:0] w, input logic g, input logic [5:0] f,
               input logic [2:0] exp);
    wr(8'hf4, w, 1'b0);
    phy_enhancement_gate <= g;
    stream_format_code <= f;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("enh_outputs", {29'h0, exp},
        {29'h0, timestamp_enhance_active, priority_arb_enable, phy_accel_notify});
  endtask : out_chk

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    errors = 0;
    checked = 0;
    sys_rst = 1'b1;
    global_reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    phy_enhancement_gate = 1'b0;
    stream_format_code = 6'h00;
    eeprom_load = '0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    global_reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(8'hf4, 32'h0, 1'b0, "enh_reset");
    rd_chk(8'hf8, 32'h0, 1'b0, "alias_reset");
    wr(8'hf4, 32'hffff_ffff, 1'b0);
    rd_chk(8'hf4, ENH_RW, 1'b0, "enh_mask");
    out_chk(ENH_RW, 1'b0, 6'h20, 3'b000);
    out_chk(ENH_RW, 1'b1, 6'h20, 3'b111);
    out_chk(32'h0000_0400, 1'b1, 6'h00, 3'b000);
    out_chk(32'h0000_0400, 1'b1, 6'h20, 3'b100);
    out_chk(32'h0000_0100, 1'b1, 6'h00, 3'b100);
    out_chk(32'h0000_0100, 1'b1, 6'h20, 3'b000);
    out_chk(32'h0000_0080, 1'b1, 6'h01, 3'b010);
    out_chk(32'h0000_0002, 1'b1, 6'h00, 3'b001);
    wr(8'hf4, ENH_RW, 1'b0);
    wr(8'hf8, 32'h1234_abcd, 1'b0);
    rd_chk(8'hf8, 32'h1234_abcd, 1'b0, "alias");
    rd_chk(8'h2c, 32'h1234_abcd, 1'b0, "subsys_id");
    chk("dev_alias", 32'h1234, {16'h0, subsystem_device_alias});
    chk("ven_alias", 32'habcd, {16'h0, subsystem_vendor_alias});
    wr(8'h2c, 32'hffff_0000, 1'b1);
    rd_chk(8'hf8, 32'h1234_abcd, 1'b0, "alias_kept");
    rd_chk(8'h10, 32'h0, 1'b1, "unmapped");
    wr(8'h10, 32'hffff_ffff, 1'b1);
    // a local reset must leave the sticky bits alone
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(8'hf4, ENH_RW, 1'b0, "enh_sys_rst");
    rd_chk(8'hf8, 32'h1234_abcd, 1'b0, "alias_sys_rst");
    wr(8'hf4, 32'h0, 1'b0);
    @(posedge clk);
    eeprom_load <= '{valid: 1'b1, data: 16'hffff};
    @(posedge clk);
    eeprom_load <= '0;
    stream_format_code <= 6'h20;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("permit", 32'h1, {31'h0, phy_program_permit});
    chk("ts_eeprom", 32'h1, {31'h0, timestamp_enhance_active});
    rd_chk(8'hf4, ENH_RW, 1'b0, "enh_eeprom");
    @(posedge clk);
    global_reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    global_reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(8'hf4, 32'h0, 1'b0, "enh_global_reset_n");
    rd_chk(8'hf8, 32'h0, 1'b0, "alias_global_reset_n");
    chk("dev_global_reset_n", 32'h0, {16'h0, subsystem_device_alias});
    chk("ven_global_reset_n", 32'h0, {16'h0, subsystem_vendor_alias});
    chk("permit_global_reset_n", 32'h0, {31'h0, phy_program_permit});
    chk("ts_global_reset_n", 32'h0, {31'h0, timestamp_enhance_active});
    test_done;
  end

  // the sequence needs well under a thousand cycles
  initial
  begin
    #40000;
    errors++;
    test_done;
  end
endmodule : tb_lesid_regs
